// [logic/cte_top.sv]
// Charge time edge control: Wishbone registers, two edge channels, gating.
//
// How it works
// - Each channel picks a pin or a compare trigger through a two-bit select.
// - Channels respond to the present source level, not to a transition.
// - One polarity bit per channel chooses which level counts as a hit.
// - With ordering enabled, only channel one before channel two is accepted.
// - Two hit flags in the low bits of the low control register; hardware sets them.
// - A setting change that matches the present level sets the flag at once.
// - Current enable is high only while exactly one flag is set.
// - Software may set or clear flags; gating follows the same one-flag rule.
// - Two-bit range field in the low bits of current control; 01 is lowest.
// - Six-bit signed trim in the upper bits; 000000 neutral, 011111 and 100001 extremes.
//
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cte_top (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic edge_pin_a,
  input wire logic edge_pin_b,
  input wire logic enhanced_cmp_trigger_a,
  input wire logic cmp_trigger_b,
  output logic current_enable,
  output logic [cte_pkg::CTE_RANGE_W-1:0] current_range_sel,
  output logic [cte_pkg::CTE_TRIM_W-1:0] current_trim
);
  import cte_pkg::*;

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  logic ack_q;
  logic req;
  logic wr_en;
  logic wr_low;
  logic wr_high;
  logic wr_cur;
  logic [7:0] rd_byte;
  logic [31:0] dat_q;
  logic [1:0] pin_meta_q;
  logic [1:0] pin_sync_q;
  logic [3:0] src_lvl;
  cte_src_t sel1_q;
  cte_src_t sel2_q;
  logic pol1_q;
  logic pol2_q;
  logic order_en_q;
  logic [CTE_RANGE_W-1:0] range_q;
  logic [CTE_TRIM_W-1:0] trim_q;
  logic flag1_q;
  logic flag2_q;
  logic allow2;
  logic cur_en_q;
  logic [7:0] low_view;

  // --------------------------------------------------------------------
  // Wishbone slave
  // --------------------------------------------------------------------

  // Every access gets one wait state; ack drops the cycle after it rose.
  assign req = wb_cyc_i & wb_stb_i;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end
  assign wb_ack_o = ack_q;

  // Writes land on the edge where the master sees ack, and only on lane 0,
  // because all fields fit into the lowest byte.
  assign wr_en = req & wb_we_i & ack_q & wb_sel_i[0];
  assign wr_low = wr_en & (wb_adr_i == CTE_ADR_EDGE_LOW);
  assign wr_high = wr_en & (wb_adr_i == CTE_ADR_EDGE_HIGH);
  assign wr_cur = wr_en & (wb_adr_i == CTE_ADR_CUR_CTRL);

  // Live view of the low control register, flags included.
  always_comb begin
    low_view = 8'h00;
    low_view[CTE_FLAG1_BIT] = flag1_q;
    low_view[CTE_FLAG2_BIT] = flag2_q;
    low_view[CTE_SEL1_LSB +: CTE_SEL_W] = sel1_q;
    low_view[CTE_POL1_BIT] = pol1_q;
    low_view[CTE_SEL2_LSB +: CTE_SEL_W] = sel2_q;
    low_view[CTE_POL2_BIT] = pol2_q;
  end

  // Read mux; unmapped offsets read as zero and are still acknowledged.
  always_comb begin
    rd_byte = 8'h00;
    unique case (wb_adr_i)
      CTE_ADR_EDGE_LOW: begin
        rd_byte = low_view;
      end
      CTE_ADR_EDGE_HIGH: begin
        rd_byte[CTE_ORDER_EN_BIT] = order_en_q;
      end
      CTE_ADR_CUR_CTRL: begin
        rd_byte[CTE_RANGE_LSB +: CTE_RANGE_W] = range_q;
        rd_byte[CTE_TRIM_LSB +: CTE_TRIM_W] = trim_q;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // Read data is captured in the wait cycle so it is stable under ack.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dat_q <= 32'h0000_0000;
    end else if (req & ~ack_q) begin
      dat_q <= {24'h00_0000, rd_byte};
    end
  end
  assign wb_dat_o = dat_q;

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------

  // Source and polarity of both channels.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sel1_q <= cte_src_t'(CTE_EDGE_LOW_RST[CTE_SEL1_LSB +: CTE_SEL_W]);
      sel2_q <= cte_src_t'(CTE_EDGE_LOW_RST[CTE_SEL2_LSB +: CTE_SEL_W]);
      pol1_q <= CTE_EDGE_LOW_RST[CTE_POL1_BIT];
      pol2_q <= CTE_EDGE_LOW_RST[CTE_POL2_BIT];
    end else if (wr_low) begin
      sel1_q <= cte_src_t'(wb_dat_i[CTE_SEL1_LSB +: CTE_SEL_W]);
      sel2_q <= cte_src_t'(wb_dat_i[CTE_SEL2_LSB +: CTE_SEL_W]);
      pol1_q <= wb_dat_i[CTE_POL1_BIT];
      pol2_q <= wb_dat_i[CTE_POL2_BIT];
    end
  end

  // Ordering filter enable.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      order_en_q <= CTE_EDGE_HIGH_RST[CTE_ORDER_EN_BIT];
    end else if (wr_high) begin
      order_en_q <= wb_dat_i[CTE_ORDER_EN_BIT];
    end
  end

  // Range and trim go straight to the analog source; the block does not
  // interpret them, so code 00 of the range is passed on as written.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      range_q <= CTE_CUR_CTRL_RST[CTE_RANGE_LSB +: CTE_RANGE_W];
      trim_q <= CTE_CUR_CTRL_RST[CTE_TRIM_LSB +: CTE_TRIM_W];
    end else if (wr_cur) begin
      range_q <= wb_dat_i[CTE_RANGE_LSB +: CTE_RANGE_W];
      trim_q <= wb_dat_i[CTE_TRIM_LSB +: CTE_TRIM_W];
    end
  end
  assign current_range_sel = range_q;
  assign current_trim = trim_q;

  // --------------------------------------------------------------------
  // Edge sources
  // --------------------------------------------------------------------

  // Pins are asynchronous and pass two flops; the compare triggers come
  // from logic on this clock and are used as they are.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pin_meta_q <= 2'b00;
      pin_sync_q <= 2'b00;
    end else begin
      pin_meta_q <= {edge_pin_b, edge_pin_a};
      pin_sync_q <= pin_meta_q;
    end
  end

  // Source order follows the select codes.
  assign src_lvl = {cmp_trigger_b, enhanced_cmp_trigger_a, pin_sync_q};

  // --------------------------------------------------------------------
  // Channels
  // --------------------------------------------------------------------

  // Channel two may only hit after channel one when ordering is on.
  assign allow2 = ~order_en_q | flag1_q;

  cte_chan u_chan1 (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .src_lvl(src_lvl),
    .sel(sel1_q),
    .pol(pol1_q),
    .allow(1'b1),
    .sw_wr(wr_low),
    .sw_val(wb_dat_i[CTE_FLAG1_BIT]),
    .flag_q(flag1_q)
  );

  cte_chan u_chan2 (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .src_lvl(src_lvl),
    .sel(sel2_q),
    .pol(pol2_q),
    .allow(allow2),
    .sw_wr(wr_low),
    .sw_val(wb_dat_i[CTE_FLAG2_BIT]),
    .flag_q(flag2_q)
  );

  // --------------------------------------------------------------------
  // Current gating
  // --------------------------------------------------------------------

  // Enable tracks the flags with one cycle lag. Software should clear both
  // flags in one write; clearing them one at a time re-enables the source.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cur_en_q <= 1'b0;
    end else begin
      cur_en_q <= flag1_q ^ flag2_q;
    end
  end
  assign current_enable = cur_en_q;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  a_cur_one_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
    ##1 (current_enable == $past(flag1_q ^ flag2_q)))
    else $error("current enable not one-flag gated");
  a_order_blocks_two: assert property (@(posedge clk_sys) disable iff (!rstn)
    (order_en_q && !flag1_q && !flag2_q && !wr_low) |=> !flag2_q)
    else $error("channel two set before channel one");
  a_pin_a_hits: assert property (@(posedge clk_sys) disable iff (!rstn)
    (sel1_q == CTE_SRC_PIN_A && edge_pin_a == pol1_q) [*3] |=> flag1_q)
    else $error("pin a level did not hit");
  a_trig_b_hits: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!order_en_q && sel2_q == CTE_SRC_TRIG_B && cmp_trigger_b == pol2_q)
    |=> flag2_q) else $error("trigger b level did not hit");
  // With ordering on and flag one clear, channel two cannot join in that edge.
  a_sw_one_flag_on: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_low && wb_dat_i[1:0] == 2'b01 && order_en_q && !flag1_q && !flag2_q)
    |=> ##1 current_enable)
    else $error("software single flag did not enable");
  a_range_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_cur |=> current_range_sel == $past(wb_dat_i[1:0]))
    else $error("range field not stored");
  a_trim_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_cur |=> current_trim == $past(wb_dat_i[7:2]))
    else $error("trim field not stored");
  a_ack_one_cycle: assert property (@(posedge clk_sys) disable iff (!rstn)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  // The new setting lands on the write edge and hits one edge later, unless the
  // trigger has moved off the written polarity in between.
  a_pol_match_sets: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_low && !wb_dat_i[0] && cte_src_t'(wb_dat_i[3:2]) == CTE_SRC_TRIG_A
     && wb_dat_i[4] == enhanced_cmp_trigger_a)
    |=> ((enhanced_cmp_trigger_a != pol1_q) or (##1 flag1_q)))
    else $error("matching setting did not set flag");

endmodule
`default_nettype wire

// [common/cte_pkg.sv]
// Shared constants and types of the charge time edge control block.
`default_nettype none
package cte_pkg;

  // --------------------------------------------------------------------
  // Register byte offsets on the bus
  // --------------------------------------------------------------------
  localparam logic [3:0] CTE_ADR_EDGE_LOW = 4'h0;
  localparam logic [3:0] CTE_ADR_EDGE_HIGH = 4'h4;
  localparam logic [3:0] CTE_ADR_CUR_CTRL = 4'h8;

  // --------------------------------------------------------------------
  // Field positions and widths
  // --------------------------------------------------------------------
  localparam int CTE_FLAG1_BIT = 0;
  localparam int CTE_FLAG2_BIT = 1;
  localparam int CTE_SEL1_LSB = 2;
  localparam int CTE_POL1_BIT = 4;
  localparam int CTE_SEL2_LSB = 5;
  localparam int CTE_POL2_BIT = 7;
  localparam int CTE_ORDER_EN_BIT = 2;
  localparam int CTE_RANGE_LSB = 0;
  localparam int CTE_TRIM_LSB = 2;
  localparam int CTE_SEL_W = 2;
  localparam int CTE_RANGE_W = 2;
  localparam int CTE_TRIM_W = 6;

  // --------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------
  localparam logic [7:0] CTE_EDGE_LOW_RST = 8'h00;
  localparam logic [7:0] CTE_EDGE_HIGH_RST = 8'h00;
  localparam logic [7:0] CTE_CUR_CTRL_RST = 8'h00;

  // Source codes of the per-channel select field.
  typedef enum logic [1:0] {
    CTE_SRC_PIN_A = 2'b00,
    CTE_SRC_PIN_B = 2'b01,
    CTE_SRC_TRIG_A = 2'b10,
    CTE_SRC_TRIG_B = 2'b11
  } cte_src_t;

endpackage
`default_nettype wire

// [logic/cte_chan.sv]
// One edge channel: source mux, polarity match and sticky hit flag.
`timescale 1ns/1ps
`default_nettype none
module cte_chan (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [3:0] src_lvl,
  input wire cte_pkg::cte_src_t sel,
  input wire logic pol,
  input wire logic allow,
  input wire logic sw_wr,
  input wire logic sw_val,
  output logic flag_q
);
  import cte_pkg::*;

  logic hit;
  logic flag_d;

  // The channel is level sensitive: it matches the present level, so a
  // change of source or polarity onto a matching level hits at once.
  assign hit = (src_lvl[sel] == pol);

  // A hit in the same cycle as a software clear wins over the clear.
  always_comb begin
    flag_d = sw_wr ? sw_val : flag_q;
    flag_d = flag_d | (hit & allow);
  end

  // Flag register.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  a_hit_sets_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
    (hit && allow) |=> flag_q) else $error("hit did not set flag");
  a_sw_clear_works: assert property (@(posedge clk_sys) disable iff (!rstn)
    (sw_wr && !sw_val && !(hit && allow)) |=> !flag_q)
    else $error("software clear lost");
  a_flag_sticky: assert property (@(posedge clk_sys) disable iff (!rstn)
    (flag_q && !sw_wr) |=> flag_q) else $error("flag dropped");
  a_no_cause_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!flag_q && !sw_wr && !(hit && allow)) |=> !flag_q)
    else $error("flag set without cause");

endmodule
`default_nettype wire

// [tb/cte_edge_src.sv]
// Behavioural model of the edge pins and compare trigger sources.
`timescale 1ns/1ps
`default_nettype none
module cte_edge_src (
  input wire logic clk_sys,
  input wire logic [3:0] lvl_cmd,
  input wire logic slow,
  output logic pin_a,
  output logic pin_b,
  output logic trig_a,
  output logic trig_b
);
  logic [1:0] pin_late_q;

  // Slow mode lags the pins one extra cycle, like a sluggish external driver.
  always_ff @(posedge clk_sys) begin
    pin_late_q <= lvl_cmd[1:0];
  end

  // The pins are asynchronous to the block; the triggers share its clock.
  assign pin_a = slow ? pin_late_q[0] : lvl_cmd[0];
  assign pin_b = slow ? pin_late_q[1] : lvl_cmd[1];
  assign trig_a = lvl_cmd[2];
  assign trig_b = lvl_cmd[3];
endmodule
`default_nettype wire

// [tb/charge_time_edge_control_bench.sv]
// Self-checking bench of the charge time edge control block.
`timescale 1ns/1ps
`default_nettype none
module charge_time_edge_control_bench;
  import cte_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [3:0] lvl = 4'h0;
  logic slow = 1'b0;
  logic pin_a, pin_b, trg_a, trg_b, cen;
  logic [1:0] rng;
  logic [5:0] trim;
  logic [7:0] r = 8'h16;
  logic [7:0] c;
  logic [1:0] s;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  // --------------------------------------------------------------------
  // Clock, partner and design
  // --------------------------------------------------------------------
  always #5 clk_sys = ~clk_sys;

  cte_edge_src u_cte_edge_src (.clk_sys(clk_sys), .lvl_cmd(lvl), .slow(slow), .pin_a(pin_a),
    .pin_b(pin_b), .trig_a(trg_a), .trig_b(trg_b));

  cte_top u_cte_top (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .edge_pin_a(pin_a), .edge_pin_b(pin_b), .enhanced_cmp_trigger_a(trg_a),
    .cmp_trigger_b(trg_b), .current_enable(cen), .current_range_sel(rng),
    .current_trim(trim));

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One classic cycle; the master waits for ack however long it takes.
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
      output logic [7:0] q);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge clk_sys); while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk("register", exp, q);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Samples mid-cycle, where the registered enable has settled, and comes back
  // on a rising edge so that later stimulus still changes at the clock.
  task automatic ce(input logic exp);
    @(negedge clk_sys);
    chk("current_enable", {7'h0, exp}, {7'h0, cen});
    @(posedge clk_sys);
  endtask

  task automatic end_of_test();
    $display("Checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // A hang counts as a mismatch and ends the run.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  initial begin
    idle(12);
    rstn <= 1'b1;
    // Both channels leave reset on pin a with low polarity, and the pins are low.
    rd(CTE_ADR_EDGE_LOW, 8'h03);
    rd(CTE_ADR_CUR_CTRL, 8'h00);
    rd(4'hc, 8'h00);
    wr(CTE_ADR_EDGE_HIGH, 8'hff);
    rd(CTE_ADR_EDGE_HIGH, 8'h04);
    // A write without byte lane 0 must leave the register alone.
    sel <= 4'he;
    wr(CTE_ADR_EDGE_HIGH, 8'h00);
    sel <= 4'hf;
    rd(CTE_ADR_EDGE_HIGH, 8'h04);
    wr(CTE_ADR_EDGE_HIGH, 8'h00);
    rd(CTE_ADR_EDGE_HIGH, 8'h00);
    // Neutral trim and both extremes first, then random settings.
    for (int i = 0; i < 8; i++) begin
      r = nxt(r);
      c = (i == 0) ? 8'h00 : (i == 1) ? 8'h7d : (i == 2) ? 8'h86 : r;
      wr(CTE_ADR_CUR_CTRL, c);
      rd(CTE_ADR_CUR_CTRL, c);
      chk("range_trim", c, {trim, rng});
    end
    // Every source code and polarity on each channel; the other channel mismatches.
    for (int ch = 0; ch < 2; ch++) begin
      for (int p = 0; p < 2; p++) begin
        for (int k = 0; k < 4; k++) begin
          s = k[1:0];
          lvl <= {4{~p[0]}};
          idle(4);
          c = ch ? {p[0], s, p[0], s + 2'd1, 2'b00} : {p[0], s + 2'd1, p[0], s, 2'b00};
          wr(CTE_ADR_EDGE_LOW, c);
          // A set wins over the clear, so an old setting still hitting survives
          // the first write; the second one runs on the new setting.
          wr(CTE_ADR_EDGE_LOW, c);
          idle(4);
          rd(CTE_ADR_EDGE_LOW, c);
          lvl[s] <= p[0];
          idle(5);
          rd(CTE_ADR_EDGE_LOW, c | (ch ? 8'h02 : 8'h01));
          ce(1'b1);
          lvl[s] <= ~p[0];
          idle(4);
          wr(CTE_ADR_EDGE_LOW, c);
          rd(CTE_ADR_EDGE_LOW, c);
        end
      end
    end
    // A setting that already matches the present level hits at once.
    slow <= 1'b1;
    repeat (4) begin
      r = nxt(r);
      s = r[5:4];
      lvl <= r[3:0];
      idle(6);
      c = {~r[s], s, ~r[s], s, 2'b00};
      wr(CTE_ADR_EDGE_LOW, c);
      wr(CTE_ADR_EDGE_LOW, c);
      rd(CTE_ADR_EDGE_LOW, c);
      c[4] = r[s];
      wr(CTE_ADR_EDGE_LOW, c);
      rd(CTE_ADR_EDGE_LOW, c | 8'h01);
    end
    // Software-set flags gate the source like hardware hits.
    c[4] = ~r[s];
    wr(CTE_ADR_EDGE_LOW, c);
    for (int f = 0; f < 4; f++) begin
      wr(CTE_ADR_EDGE_LOW, c | f[7:0]);
      rd(CTE_ADR_EDGE_LOW, c | f[7:0]);
      ce(f == 1 || f == 2);
    end
    // Ordered pair on the triggers: channel two early is dropped.
    wr(CTE_ADR_EDGE_LOW, c);
    lvl <= 4'h0;
    wr(CTE_ADR_EDGE_HIGH, 8'h04);
    wr(CTE_ADR_EDGE_LOW, 8'hf8);
    wr(CTE_ADR_EDGE_LOW, 8'hf8);
    lvl <= 4'h8;
    idle(3);
    rd(CTE_ADR_EDGE_LOW, 8'hf8);
    lvl <= 4'h4;
    idle(3);
    rd(CTE_ADR_EDGE_LOW, 8'hf9);
    ce(1'b1);
    lvl <= 4'hc;
    idle(3);
    rd(CTE_ADR_EDGE_LOW, 8'hfb);
    ce(1'b0);
    lvl <= 4'h0;
    idle(2);
    wr(CTE_ADR_EDGE_LOW, 8'hf8);
    idle(2);
    ce(1'b0);
    // With ordering on, a software set of flag one alone enables the source.
    wr(CTE_ADR_EDGE_LOW, 8'hf9);
    idle(2);
    ce(1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
